// file: hw/slt_pkg.sv
// package: link mode table, register map and fixed alignment fields
package slt_pkg;

  localparam int unsigned NUM_LANES = 8;
  localparam int unsigned SMP_W     = 12;
  localparam int unsigned MAX_SMP   = 40;
  localparam int unsigned LANE_W    = 64;
  localparam int unsigned STREAM_W  = SMP_W * MAX_SMP;
  localparam int unsigned DATA_W    = LANE_W * NUM_LANES;
  localparam int unsigned K_FACT    = 8 * 32;

  // register map (byte addresses)
  localparam logic [7:0] REG_MODE = 8'h00;
  localparam logic [7:0] REG_KM1  = 8'h04;
  localparam logic [7:0] REG_DID  = 8'h08;
  localparam logic [7:0] REG_SCR  = 8'h0C;
  localparam logic [7:0] REG_STAT = 8'h10;
  localparam logic [7:0] REG_PAR0 = 8'h14;
  localparam logic [7:0] REG_PAR1 = 8'h18;
  localparam logic [7:0] REG_CSUM = 8'h1C;

  // reset values
  localparam logic [3:0]  MODE_RST = 4'h0;
  localparam logic [7:0]  KM1_RST  = 8'h1F;
  localparam logic [7:0]  DID_RST  = 8'h00;
  // lane identifier of lane l sits at bits 3l+2:3l
  localparam logic [23:0] LID_MAP  = 24'hFA_C688;

  // fixed alignment fields
  localparam logic [7:0] ILA_ZERO = 8'h00;
  localparam logic [7:0] ILA_ONE  = 8'h01;

  typedef struct packed {
    logic       valid;
    logic       enc64;
    logic [3:0] lanes;
    logic [3:0] m;
    logic [3:0] f;
    logic [2:0] s;
    logic       hd;
    logic [1:0] e;
    logic [3:0] n;
    logic [2:0] kstep;
    logic [2:0] tail;
    logic [8:0] r16;
  } slt_cfg_t;

  // r16 is the line-rate factor in sixteenths
  function automatic slt_cfg_t slt_mode_cfg(input logic [3:0] mode);
    slt_cfg_t c;
    c = '0;
    case (mode)
      4'h0: c = '{1'b1, 1'b0, 4'h8, 4'h8, 4'h8, 3'h5, 1'b0, 2'h0, 4'hC, 3'h2, 3'h4, 9'h080};
      4'h1: c = '{1'b1, 1'b0, 4'h6, 4'h4, 4'h2, 3'h2, 1'b1, 2'h0, 4'hC, 3'h4, 3'h0, 9'h0A0};
      4'h2: c = '{1'b1, 1'b0, 4'h4, 4'h4, 4'h1, 3'h1, 1'b0, 2'h0, 4'h8, 3'h5, 3'h0, 9'h0A0};
      4'h3: c = '{1'b1, 1'b0, 4'h4, 4'h4, 4'h5, 3'h4, 1'b0, 2'h0, 4'hA, 3'h5, 3'h0, 9'h0C8};
      4'h4: c = '{1'b1, 1'b1, 4'h3, 4'h4, 4'h2, 3'h1, 1'b1, 2'h3, 4'hC, 3'h0, 3'h0, 9'h108};
      4'h5: c = '{1'b1, 1'b1, 4'h2, 4'h4, 4'h2, 3'h1, 1'b0, 2'h1, 4'h8, 3'h0, 3'h0, 9'h108};
      4'h6: c = '{1'b1, 1'b1, 4'h6, 4'h4, 4'h2, 3'h2, 1'b1, 2'h3, 4'hC, 3'h0, 3'h0, 9'h084};
      4'h7: c = '{1'b1, 1'b1, 4'h4, 4'h4, 4'h1, 3'h1, 1'b0, 2'h1, 4'h8, 3'h0, 3'h0, 9'h084};
      4'h8: c = '{1'b1, 1'b1, 4'h4, 4'h4, 4'h3, 3'h2, 1'b0, 2'h3, 4'hC, 3'h0, 3'h0, 9'h0C6};
      4'h9: c = '{1'b1, 1'b0, 4'h8, 4'h4, 4'h1, 3'h2, 1'b0, 2'h0, 4'h8, 3'h5, 3'h0, 9'h050};
      4'hA: c = '{1'b1, 1'b0, 4'h8, 4'h8, 4'h5, 3'h4, 1'b0, 2'h0, 4'hA, 3'h5, 3'h0, 9'h064};
      4'hE: c = '{1'b1, 1'b1, 4'h8, 4'h8, 4'h3, 3'h2, 1'b0, 2'h3, 4'hC, 3'h0, 3'h0, 9'h063};
      default: c = '0;
    endcase
    return c;
  endfunction

endpackage

// file: hw/slt_framer.sv
// link mode decoder, alignment fields and transport framer
// What this block does
// - fixed alignment fields sent as zero or one
// - control bits per sample reported as zero
// - programmed link identifier carried on LINK_ID and in every lane checksum
// - lane identifier equals lane index zero to seven
// - 8b10b multiframe length from programmed register
// - checksum is field sum modulo 256
// - mode 0 parameters
// - mode 1 parameters
// - mode 2 parameters
// - mode 3 parameters
// - mode 4 parameters
// - mode 5 parameters
// - mode 6 parameters
// - mode 7 parameters
// - mode 8 parameters
// - mode 9 parameters
// - mode 10 parameters
// - mode 14 parameters; other codes unsupported
// - 64b66b multiframe length fixed by E and F
// - lowest lanes used, upper lanes powered down
// - samples msb first, tail bits zero
// - line rate factor R reported per mode
// - E ignored in 8b10b, K ignored in 64b66b
`timescale 1ns/1ps
`default_nettype none

module slt_framer
  import slt_pkg::*;
(
  // clock and reset
  input  wire logic                         MCLK,
  input  wire logic                         RST,
  // register port
  input  wire logic [7:0]                   REG_ADDR,
  input  wire logic [31:0]                  REG_WDATA,
  input  wire logic                         REG_WR,
  input  wire logic                         REG_RD,
  output var  logic [31:0]                  REG_RDATA,
  // sample input, one frame of samples per valid cycle
  input  wire logic [slt_pkg::STREAM_W-1:0] SMP_IN,
  input  wire logic                         SMP_VALID,
  // lane side
  output var  logic [slt_pkg::DATA_W-1:0]   LANE_DATA,
  output var  logic                         LANE_VALID,
  output var  logic [7:0]                   LANE_PWRDN,
  output var  logic [23:0]                  LANE_ID,
  output var  logic [7:0]                   LINK_ID,
  output var  logic [63:0]                  ILA_CHKSUM,
  output var  logic [8:0]                   LINE_RATE_X16,
  output var  logic                         CFG_ERR
);
  import slt_pkg::*;

  typedef struct packed {
    logic [3:0]        mode;
    logic [7:0]        km1;
    logic [7:0]        did;
    logic              scr;
    logic [31:0]       rdata;
    logic              cfg_err;
    logic [7:0]        pwrdn;
    logic [23:0]       lid;
    logic [63:0]       chk;
    logic [DATA_W-1:0] data;
    logic              valid;
    logic [8:0]        r16;
  } slt_state_t;

  localparam slt_state_t ST_RST = '{mode: MODE_RST, km1: KM1_RST, did: DID_RST,
                                    lid: LID_MAP, pwrdn: 8'hFF, default: '0};

  slt_state_t          st_q;
  slt_state_t          st_d;
  slt_cfg_t            cfg;
  logic [10:0]         kval;
  logic [7:0]          kmask;
  logic                kerr;
  logic [6:0]          share;
  logic [5:0]          nsmp;
  logic [LANE_W-1:0]   lane_mask;
  logic [STREAM_W-1:0] stream;
  logic [7:0]          ila_base;
  logic [DATA_W-1:0]   data_vec;
  logic [63:0]         chk_vec;
  logic [7:0]          pwr_off;

  function automatic logic [7:0] m1(input logic [10:0] v);
    return 8'(v - 11'h001);
  endfunction

  // left-justified bit stream of the first nsmp samples, each cut to n bits
  function automatic logic [STREAM_W-1:0] pack_stream(input logic [STREAM_W-1:0] smp_in,
                                                      input logic [5:0] cnt,
                                                      input logic [3:0] n);
    logic [STREAM_W-1:0] acc;
    logic [SMP_W-1:0]    smp;
    logic [SMP_W-1:0]    smask;
    acc   = '0;
    smask = 12'(12'hFFF << (4'hC - n));
    for (int j = 0; j < MAX_SMP; j++)
    begin
      smp = smp_in[STREAM_W-1-j*SMP_W -: SMP_W] & smask;
      if (6'(j) < cnt)
        acc = acc | ({smp, {(STREAM_W-SMP_W){1'b0}}} >> (j * n));
    end
    return acc;
  endfunction

  assign cfg = slt_mode_cfg(st_q.mode);

  // k in 64b66b comes from E and F; the programmed value only counts for 8b10b
  assign kval = cfg.enc64 ?
                ((cfg.f == 4'h0) ? 11'h000 : 11'((K_FACT * cfg.e) / cfg.f)) :
                {3'h0, st_q.km1} + 11'h001;

  // allowed K is a multiple of a power-of-two step, so K-1 ends in ones
  assign kmask = 8'((9'h001 << cfg.kstep) - 9'h001);
  assign kerr  = !cfg.enc64 && ((st_q.km1 & kmask) != kmask);

  assign share     = 7'({3'h0, cfg.f} * 7'h08) - 7'(cfg.tail);
  assign nsmp      = 6'(cfg.m * cfg.s);
  assign lane_mask = {LANE_W{1'b1}} << (7'h40 - share);
  assign stream    = pack_stream(SMP_IN, nsmp, cfg.n);

  // sum of every field except the lane identifier; cs, cf, hd, adjust, bank, reserved are zero
  // hd goes out as zero even in split-sample modes, so the real format flag stays out of it
  assign ila_base = st_q.did + {7'h00, st_q.scr} + ILA_ZERO + ILA_ZERO + ILA_ZERO +
                    m1(11'(cfg.lanes)) + m1(11'(cfg.f)) + m1(kval) + m1(11'(cfg.m)) +
                    m1(11'(cfg.n)) + m1(11'(cfg.n)) + ILA_ONE + ILA_ONE +
                    m1(11'(cfg.s)) + ILA_ZERO;

  // the same stream split into equal lane shares; leftover bits are tail zeros
  for (genvar l = 0; l < NUM_LANES; l++)
  begin : g_lane
    logic [STREAM_W-1:0] shifted;
    logic                used;
    assign used    = 4'(l) < cfg.lanes;
    assign shifted = stream << (l * share);
    assign data_vec[DATA_W-1-l*LANE_W -: LANE_W] =
      used ? (shifted[STREAM_W-1 -: LANE_W] & lane_mask) : '0;
    assign chk_vec[8*l +: 8] = ila_base + 8'(l);
    assign pwr_off[l]        = !used;
  end

  always_comb
  begin
    st_d       = st_q;
    st_d.rdata = '0;
    if (REG_WR)
    begin
      case (REG_ADDR)
        REG_MODE: st_d.mode = REG_WDATA[3:0];
        REG_KM1:  st_d.km1  = REG_WDATA[7:0];
        REG_DID:  st_d.did  = REG_WDATA[7:0];
        REG_SCR:  st_d.scr  = REG_WDATA[0];
        default:  st_d.scr  = st_q.scr;
      endcase
    end
    if (REG_RD)
    begin
      case (REG_ADDR)
        REG_MODE: st_d.rdata = {28'h000_0000, st_q.mode};
        REG_KM1:  st_d.rdata = {24'h00_0000, st_q.km1};
        REG_DID:  st_d.rdata = {24'h00_0000, st_q.did};
        REG_SCR:  st_d.rdata = {31'h0000_0000, st_q.scr};
        REG_STAT: st_d.rdata = {29'h0000_0000, cfg.enc64, cfg.valid, st_q.cfg_err};
        REG_PAR0: st_d.rdata = {7'h00, cfg.r16, cfg.lanes, cfg.m, cfg.f, 1'b0, cfg.s};
        REG_PAR1: st_d.rdata = {14'h0000, cfg.hd, cfg.e, cfg.n, kval};
        REG_CSUM: st_d.rdata = st_q.chk[31:0];
        default:  st_d.rdata = '0;
      endcase
    end
    st_d.cfg_err = !cfg.valid || kerr;
    st_d.pwrdn   = pwr_off;
    st_d.lid     = LID_MAP;
    st_d.chk     = chk_vec;
    st_d.r16     = cfg.r16;
    st_d.valid   = SMP_VALID && cfg.valid && !kerr;
    // last good frame is held so idle cycles do not glitch the lanes
    if (SMP_VALID && cfg.valid && !kerr)
      st_d.data = data_vec;
  end

  always_ff @(posedge MCLK)
  begin
    if (RST)
      st_q <= ST_RST;
    else
      st_q <= st_d;
  end

  assign REG_RDATA     = st_q.rdata;
  assign LANE_DATA     = st_q.data;
  assign LANE_VALID    = st_q.valid;
  assign LANE_PWRDN    = st_q.pwrdn;
  assign LANE_ID       = st_q.lid;
  assign LINK_ID       = st_q.did;
  assign ILA_CHKSUM    = st_q.chk;
  assign LINE_RATE_X16 = st_q.r16;
  assign CFG_ERR       = st_q.cfg_err;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  sequence s_bad_k_write;
    REG_WR && REG_ADDR == REG_KM1 && REG_WDATA[1:0] != 2'h3 && st_q.mode == 4'h0;
  endsequence

  sequence s_quiet;
    !REG_WR;
  endsequence

  AST_BAD_K: assert property (s_bad_k_write ##1 s_quiet |=> CFG_ERR)
    else $error("bad multiframe length not flagged");

  AST_CSUM: assert property (st_q.mode == 4'h2 && st_q.did == 8'h00 && !st_q.scr &&
                             st_q.km1 == 8'h1F |=> ILA_CHKSUM[7:0] == 8'h35)
    else $error("lane 0 checksum wrong in mode 2");

  AST_LID_SUM: assert property (!$past(RST) |->
                                ILA_CHKSUM[63:56] == ILA_CHKSUM[7:0] + 8'h07)
    else $error("lane 7 checksum does not reflect its lane index");

  AST_RATE: assert property (st_q.mode == 4'hE |=> LINE_RATE_X16 == 9'h063)
    else $error("mode 14 line rate factor wrong");

  AST_PWRDN: assert property (st_q.mode == 4'h5 |=> LANE_PWRDN == 8'hFC)
    else $error("mode 5 lane power-down wrong");

  AST_UNSUP: assert property (st_q.mode == 4'hB |=> CFG_ERR && LANE_PWRDN == 8'hFF)
    else $error("unsupported mode not rejected");

  AST_TAIL: assert property (LANE_VALID && $past(st_q.mode) == 4'h0 |->
                             LANE_DATA[3:0] == 4'h0 && LANE_DATA[67:64] == 4'h0)
    else $error("tail bits not zero");

  AST_MSB: assert property (LANE_VALID && $past(st_q.mode) == 4'h2 |->
                            LANE_DATA[511:504] == $past(SMP_IN[479:472]))
    else $error("sample not placed msb first");

  AST_K64: assert property (cfg.enc64 && $stable(st_q.mode) && $changed(st_q.km1) &&
                            $stable(st_q.did) && $stable(st_q.scr) |=> $stable(ILA_CHKSUM))
    else $error("k register affected a 64b66b mode");

  AST_LINK: assert property (REG_WR && REG_ADDR == REG_DID |=> ##1
                             LINK_ID == $past(REG_WDATA[7:0], 2))
    else $error("link identifier not carried");

  // per-mode rate factor and lane use, one cycle after the mode is seen
  AST_MODE0: assert property (st_q.mode == 4'h0 |=>
                              LINE_RATE_X16 == 9'h080 && LANE_PWRDN == 8'h00)
    else $error("mode 0 rate or lane use wrong");

  AST_MODE1: assert property (st_q.mode == 4'h1 |=>
                              LINE_RATE_X16 == 9'h0A0 && LANE_PWRDN == 8'hC0)
    else $error("mode 1 rate or lane use wrong");

  AST_MODE2: assert property (st_q.mode == 4'h2 |=>
                              LINE_RATE_X16 == 9'h0A0 && LANE_PWRDN == 8'hF0)
    else $error("mode 2 rate or lane use wrong");

  AST_MODE3: assert property (st_q.mode == 4'h3 |=>
                              LINE_RATE_X16 == 9'h0C8 && LANE_PWRDN == 8'hF0)
    else $error("mode 3 rate or lane use wrong");

  AST_MODE4: assert property (st_q.mode == 4'h4 |=>
                              LINE_RATE_X16 == 9'h108 && LANE_PWRDN == 8'hF8)
    else $error("mode 4 rate or lane use wrong");

  AST_MODE6: assert property (st_q.mode == 4'h6 |=>
                              LINE_RATE_X16 == 9'h084 && LANE_PWRDN == 8'hC0)
    else $error("mode 6 rate or lane use wrong");

  AST_MODE7: assert property (st_q.mode == 4'h7 |=>
                              LINE_RATE_X16 == 9'h084 && LANE_PWRDN == 8'hF0)
    else $error("mode 7 rate or lane use wrong");

  AST_MODE8: assert property (st_q.mode == 4'h8 |=>
                              LINE_RATE_X16 == 9'h0C6 && LANE_PWRDN == 8'hF0)
    else $error("mode 8 rate or lane use wrong");

  AST_MODE9: assert property (st_q.mode == 4'h9 |=>
                              LINE_RATE_X16 == 9'h050 && LANE_PWRDN == 8'h00)
    else $error("mode 9 rate or lane use wrong");

  AST_MODE10: assert property (st_q.mode == 4'hA |=>
                               LINE_RATE_X16 == 9'h064 && LANE_PWRDN == 8'h00)
    else $error("mode 10 rate or lane use wrong");

  // frame path: taken on the valid edge, answered one cycle later
  sequence s_mode2_frame;
    SMP_VALID && st_q.mode == 4'h2 && st_q.km1 == 8'h1F;
  endsequence

  sequence s_unsup_frame;
    SMP_VALID && !cfg.valid;
  endsequence

  AST_FRAME_PASS: assert property (s_mode2_frame |=> LANE_VALID)
    else $error("good frame not passed");

  AST_FRAME_DROP: assert property (s_unsup_frame |=>
                                   !LANE_VALID && $stable(LANE_DATA))
    else $error("frame passed in unsupported mode");

  AST_ONE_PULSE: assert property (!SMP_VALID |=> !LANE_VALID)
    else $error("lane valid without a frame");

  AST_HOLD_DATA: assert property (!SMP_VALID |=> $stable(LANE_DATA))
    else $error("lane data changed without a frame");

  AST_UPPER_ZERO: assert property (LANE_VALID && $past(st_q.mode) == 4'h2 |->
                                   LANE_DATA[255:0] == '0)
    else $error("unused lanes not zero");

  AST_SLOT_PAD: assert property (LANE_VALID && $past(st_q.mode) == 4'h2 |->
                                 LANE_DATA[503:448] == '0)
    else $error("lane 0 padding not zero in mode 2");

  // lane 0 checksums with link id, scrambler and K at their reset values
  AST_HD_CSUM: assert property (st_q.mode == 4'h1 && st_q.did == 8'h00 && !st_q.scr &&
                                st_q.km1 == 8'h1F |=> ILA_CHKSUM[7:0] == 8'h41)
    else $error("high-density flag leaked into checksum");

  AST_CSUM_M0: assert property (st_q.mode == 4'h0 && st_q.did == 8'h00 && !st_q.scr &&
                                st_q.km1 == 8'h1F |=> ILA_CHKSUM[7:0] == 8'h50)
    else $error("lane 0 checksum wrong in mode 0");

  AST_CSUM_64: assert property (st_q.mode == 4'h5 && st_q.did == 8'h00 && !st_q.scr &&
                                st_q.km1 == 8'h1F |=> ILA_CHKSUM[7:0] == 8'h94)
    else $error("derived multiframe length wrong in mode 5");

  AST_CFG_OK: assert property (st_q.mode == 4'h2 && st_q.km1 == 8'h1F |=> !CFG_ERR)
    else $error("allowed multiframe length flagged");

  AST_ENC64_OK: assert property (cfg.enc64 |=> !CFG_ERR)
    else $error("k register flagged in a 64b66b mode");

  AST_LANE_ID: assert property (LANE_ID[2:0] == 3'h0 && LANE_ID[5:3] == 3'h1 &&
                                LANE_ID[8:6] == 3'h2 && LANE_ID[11:9] == 3'h3 &&
                                LANE_ID[14:12] == 3'h4 && LANE_ID[17:15] == 3'h5 &&
                                LANE_ID[20:18] == 3'h6 && LANE_ID[23:21] == 3'h7)
    else $error("lane identifier differs from lane index");

  AST_LINK_HOLD: assert property (!$past(REG_WR) |-> $stable(LINK_ID))
    else $error("link identifier moved without a write");

  AST_RD_DID: assert property (REG_RD && REG_ADDR == REG_DID |=>
                               REG_RDATA == {24'h00_0000, LINK_ID})
    else $error("link identifier readback wrong");

  AST_RD_IDLE: assert property (!$past(REG_RD) |-> REG_RDATA == 32'h0000_0000)
    else $error("read data not zero outside a read");

  AST_RD_UNMAP: assert property (REG_RD && REG_ADDR == 8'hFC |=> REG_RDATA == 32'h0000_0000)
    else $error("unmapped read not zero");

  AST_CHK_NEXT: assert property (!$past(RST) |->
                                 ILA_CHKSUM[15:8] == ILA_CHKSUM[7:0] + 8'h01)
    else $error("lane 1 checksum does not reflect its lane index");

endmodule

`default_nettype wire

// file: tb/slt_rx_model.sv
// receiving logic model: captures frames on lane 0 while it is in use
`timescale 1ns/1ps
`default_nettype none

module slt_rx_model
(
  // clock and reset
  input  wire logic         MCLK,
  input  wire logic         RST,
  // lane side
  input  wire logic [511:0] LANE_DATA,
  input  wire logic         LANE_VALID,
  input  wire logic [7:0]   LANE_PWRDN,
  input  wire logic [7:0]   LINK_ID,
  // capture
  output var  logic [31:0]  FRAMES,
  output var  logic [7:0]   SEEN_LINK,
  output var  logic [63:0]  LANE0_WORD
);
  // only lane 0 is read, and only while powered; the link identifier is recorded with each frame
  always @(posedge MCLK)
  begin
    if (RST)
    begin
      FRAMES     <= 32'h0000_0000;
      SEEN_LINK  <= 8'h00;
      LANE0_WORD <= 64'h0000_0000_0000_0000;
    end
    else if (LANE_VALID && !LANE_PWRDN[0])
    begin
      FRAMES     <= FRAMES + 32'h0000_0001;
      SEEN_LINK  <= LINK_ID;
      // streams of lanes would be interleaved here when M equals L
      LANE0_WORD <= LANE_DATA[511 -: 64];
    end
  end
endmodule
`default_nettype wire

// file: tb/serial_link_transport_mode_config_tb.sv
// self-checking bench of the link mode decoder and framer
`timescale 1ns/1ps
`default_nettype none

module serial_link_transport_mode_config_tb;
  import slt_pkg::*;
  logic                MCLK = 1'b0;
  logic                RST = 1'b1;
  logic [7:0]          REG_ADDR = 8'h00;
  logic [31:0]         REG_WDATA = 32'h0000_0000;
  logic                REG_WR = 1'b0;
  logic                REG_RD = 1'b0;
  logic [31:0]         REG_RDATA;
  logic [STREAM_W-1:0] SMP_IN = '0;
  logic                SMP_VALID = 1'b0;
  logic [DATA_W-1:0]   LANE_DATA;
  logic                LANE_VALID;
  logic [7:0]          LANE_PWRDN;
  logic [23:0]         LANE_ID;
  logic [7:0]          LINK_ID;
  logic [63:0]         ILA_CHKSUM;
  logic [8:0]          LINE_RATE_X16;
  logic                CFG_ERR;
  logic [31:0]         frames;
  logic [7:0]          seen_link;
  logic [63:0]         lane0_word;
  int                  num_errors = 0;
  int                  n_checks = 0;
  int                  cycles = 0;
  int                  md[12] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 14};
  int                  ln[12] = '{8, 6, 4, 4, 3, 2, 6, 4, 4, 8, 8, 8};
  int                  rt[12] = '{128, 160, 160, 200, 264, 264, 132, 132, 198, 80, 100, 99};

  slt_framer u_slt_framer (.MCLK(MCLK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .SMP_IN(SMP_IN),
    .SMP_VALID(SMP_VALID), .LANE_DATA(LANE_DATA), .LANE_VALID(LANE_VALID),
    .LANE_PWRDN(LANE_PWRDN), .LANE_ID(LANE_ID), .LINK_ID(LINK_ID), .ILA_CHKSUM(ILA_CHKSUM),
    .LINE_RATE_X16(LINE_RATE_X16), .CFG_ERR(CFG_ERR));
  slt_rx_model u_slt_rx_model (.MCLK(MCLK), .RST(RST), .LANE_DATA(LANE_DATA),
    .LANE_VALID(LANE_VALID), .LANE_PWRDN(LANE_PWRDN), .LINK_ID(LINK_ID), .FRAMES(frames),
    .SEEN_LINK(seen_link), .LANE0_WORD(lane0_word));

  initial
  begin
    forever #2 MCLK = ~MCLK;
  end

  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  always @(posedge MCLK)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      num_errors = num_errors + 1;
      finish_test();
    end
  end

  task automatic chk(input logic [63:0] exp, input logic [63:0] got);
    n_checks = n_checks + 1;
    if (got !== exp)
    begin
      num_errors = num_errors + 1;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  // write, then let the derived outputs settle two edges later
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge MCLK);
    REG_ADDR  <= a;
    REG_WDATA <= d;
    REG_WR    <= 1'b1;
    @(posedge MCLK);
    REG_WR    <= 1'b0;
    repeat (2) @(posedge MCLK);
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge MCLK);
    REG_ADDR <= a;
    REG_RD   <= 1'b1;
    @(posedge MCLK);
    REG_RD   <= 1'b0;
    #1;
    d = REG_RDATA;
  endtask

  // one frame in; lane outputs stand one cycle later
  task automatic frame(input logic [STREAM_W-1:0] s, input logic exp_valid);
    @(posedge MCLK);
    SMP_IN    <= s;
    SMP_VALID <= 1'b1;
    @(posedge MCLK);
    SMP_VALID <= 1'b0;
    #1;
    chk(64'(exp_valid), 64'(LANE_VALID));
  endtask

  initial
  begin
    logic [31:0]         r;
    logic [STREAM_W-1:0] s;
    repeat (12) @(posedge MCLK);
    RST <= 1'b0;
    repeat (3) @(posedge MCLK);
    #1;
    chk(64'(24'hFA_C688), 64'(LANE_ID));
    for (int i = 0; i < 12; i++)
    begin
      wr(REG_MODE, 32'(md[i]));
      chk(64'(8'(8'hFF << ln[i])), 64'(LANE_PWRDN));
      chk(64'(rt[i]), 64'(LINE_RATE_X16));
      chk(64'h0, 64'(CFG_ERR));
    end
    wr(REG_MODE, 32'h0000_000B);
    chk(64'h1, 64'(CFG_ERR));
    frame('0, 1'b0);
    wr(REG_MODE, 32'h0000_0000);
    wr(REG_KM1, 32'h0000_0002);
    chk(64'h1, 64'(CFG_ERR));
    wr(REG_MODE, 32'h0000_0005);
    chk(64'h0, 64'(CFG_ERR));
    rd(REG_PAR1, r);
    chk(64'h0000_C080, 64'(r));
    wr(REG_KM1, 32'h0000_001F);
    wr(REG_DID, 32'h0000_005A);
    chk(64'h5A, 64'(LINK_ID));
    rd(REG_DID, r);
    chk(64'h5A, 64'(r));
    rd(8'hFC, r);
    chk(64'h0, 64'(r));
    // mode 0: five full samples then four tail bits per lane
    wr(REG_MODE, 32'h0000_0000);
    frame({STREAM_W{1'b1}}, 1'b1);
    chk(64'hFFFF_FFFF_FFFF_FFF0, LANE_DATA[511 -: 64]);
    chk(64'hFFFF_FFFF_FFFF_FFF0, LANE_DATA[63:0]);
    // mode 2: one eight-bit sample per lane, top bits of each slot
    wr(REG_MODE, 32'h0000_0002);
    s = '0;
    for (int j = 0; j < 4; j++)
      s[STREAM_W-1-12*j -: 12] = {8'(8'hA1 + j), 4'h0};
    frame(s, 1'b1);
    for (int l = 0; l < 4; l++)
      chk({8'(8'hA1 + l), 56'h0}, LANE_DATA[511-64*l -: 64]);
    chk(64'h0, LANE_DATA[255:0] == '0 ? 64'h0 : 64'h1);
    chk(64'h9695_9493_9291_908F, ILA_CHKSUM);
    @(posedge MCLK);
    #1;
    chk(64'h5A, 64'(seen_link));
    chk(64'h2, 64'(frames));
    chk({8'hA1, 56'h0}, lane0_word);
    finish_test();
  end
endmodule
`default_nettype wire
